// file: timer_two_pkg.sv
// package with register map, field positions and reset values for the timer two unit
package timer_two_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] idx_count = 8'h09;
  localparam logic [7:0] idx_control_one = 8'h0a;
  localparam logic [7:0] idx_control_two = 8'h0b;
  localparam logic [7:0] idx_duty_low = 8'h0c;
  localparam logic [7:0] idx_prescale_count = 8'h0d;
  localparam logic [7:0] idx_buzzer_control = 8'h0e;
  localparam logic [7:0] idx_high_bits = 8'h14;
  // control one fields
  localparam int ctl1_timer_enable = 0;
  localparam int ctl1_reload_enable = 1;
  localparam int ctl1_one_shot = 2;
  localparam int ctl1_high_osc = 3;
  localparam int ctl1_pwm_active_low = 6;
  localparam int ctl1_pwm_output_enable = 7;
  // control two fields
  localparam int ctl2_rate_lsb = 0;
  localparam int ctl2_prescale_enable_n = 3;
  localparam int ctl2_edge_select = 4;
  localparam int ctl2_clock_source = 5;
  // buzzer control fields
  localparam int bz_freq_lsb = 0;
  localparam int bz_enable = 7;
  // shared high bits fields
  localparam int hb_duty_lsb = 2;
  localparam int hb_reload_lsb = 6;
  // widths
  localparam int counter_width = 10;
  localparam int prescale_width = 8;
  // reset values and counter constants
  localparam logic [7:0] rst_control_one = 8'h00;
  localparam logic [7:0] rst_control_two = 8'h3f;
  localparam logic [7:0] rst_buzzer = 8'h0f;
  localparam logic [7:0] rst_prescale = 8'hff;
  localparam logic [7:0] rst_zero_byte = 8'h00;
  localparam logic [9:0] counter_all_ones = 10'h3ff;
  localparam logic [9:0] counter_zero = 10'h000;
  localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage : timer_two_pkg

// file: prescale_if.sv
// interface carrying the prescaler's input tick, settings and results
`timescale 1ns/1ps
interface prescale_if;
  logic src_tick; // selected timer input clock, one-cycle enable
  logic enable_n; // low enables the divider
  logic [2:0] rate; // division select
  logic out_tick; // tick delivered to the down-counter
  logic [7:0] value; // live prescaler count
  modport divider (input src_tick, input enable_n, input rate, output out_tick, output value);
  modport user (output src_tick, output enable_n, output rate, input out_tick, input value);
endinterface : prescale_if

// file: ext_edge_detect.sv
// synchroniser and edge detector for the external count clock pin
`timescale 1ns/1ps
module ext_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta; // first stage, read only by the second
  logic sync; // safe copy of the pin
  logic last; // previous safe value for edge compare

  // two stages before any logic looks at the pin, then one for history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise = sync & ~last;
  assign fall = ~sync & last;
endmodule : ext_edge_detect

// file: prescale_divider.sv
// eight-bit down-counting prescaler with a power-of-two tick output
`timescale 1ns/1ps
module prescale_divider (
  input wire logic pclk,
  input wire logic presetn,
  prescale_if.divider pif
);
  logic [7:0] count; // live count, all ones at reset
  logic [8:0] mask; // low bits that must be zero for a tick
  logic hit; // divided tick position reached

  // rate n divides by 2^(n+1): 000 -> 1:2, 111 -> 1:256
  assign mask = 9'((9'h001 << (4'(pif.rate) + 4'h1)) - 9'h001); // R10
  assign hit = (count & mask[7:0]) == 8'h00;
  // disabled divider passes the source straight through
  assign pif.out_tick = pif.enable_n ? pif.src_tick : (pif.src_tick & hit); // R10
  assign pif.value = count;

  // counts down on each source tick while enabled; parked at all ones otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= timer_two_pkg::rst_prescale; // R16
    end else if (pif.enable_n) begin
      count <= timer_two_pkg::rst_prescale;
    end else if (pif.src_tick) begin
      count <= count - 8'h01;
    end
  end
endmodule : prescale_divider

// file: timer_two_unit.sv
// timer two unit: apb registers, 10-bit down-counter, pwm and buzzer outputs
//
// Notes on behaviour
// R1: count read returns low counter byte
// R2: count write loads all ten counter bits
// R3: high oscillator select overrides channel sources
// R4: counter advances only while enabled
// R5: free-run without reload restarts at 0x3FF
// R6: free-run with reload restarts at reload value
// R7: one-shot stops at underflow regardless reload
// R8: polarity bit makes pwm active low
// R9: pwm drives both pins only when enabled
// R10: prescaler divides by two to rate plus one
// R11: software changes rate only with prescaler off
// R12: software disables prescaler on high oscillator
// R13: external clock counts on selected pin edge
// R14: source bit picks external pin or internal
// R15: frame is reload value, duty ten bits
// R16: prescaler count readable, resets all ones
// R17: buzzer field picks prescaler or counter bit
// R18: buzzer drives only while buzzer enabled
// R19: pwm active while counter at or below duty
// R20: underflow raises one-cycle event flag
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module timer_two_unit (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer input clocks as one-cycle enables from the clock tree
  input wire logic instr_tick,
  input wire logic high_osc_tick,
  // external count clock pin, asynchronous
  input wire logic ext_clock_pin,
  // pwm pins: level and select of the pwm over the general-purpose port
  output logic pwm_pin_a_out,
  output logic pwm_pin_a_sel,
  output logic pwm_pin_b_out,
  output logic pwm_pin_b_sel,
  // buzzer and underflow event
  output logic buzzer_out,
  output logic timer_underflow
);
  // software-visible registers
  logic [7:0] timer_two_control_one; // enables, mode, polarity
  logic [7:0] timer_two_control_two; // source, edge, prescaler
  logic [7:0] pwm_two_duty_low; // low duty byte, write only
  logic [7:0] buzzer_two_control; // buzzer enable and frequency
  logic [7:0] shared_timer_high_bits; // reload and duty upper bits
  logic [7:0] reload_low; // timer reload low byte
  // counter state
  logic [9:0] counter; // live down-counter
  logic stopped; // one-shot finished, held until reloaded
  // output stage levels, combinational; the pin flops register them
  logic pwm_level;
  logic buzz_level;

  // field views of the control registers
  logic timer_enable;
  logic reload_enable;
  logic one_shot_select;
  logic shared_high_osc_select;
  logic pwm_active_low;
  logic pwm_output_enable;
  logic [2:0] prescale_rate_field;
  logic prescale_enable_n;
  logic ext_edge_select;
  logic clock_source_select;
  logic [3:0] buzzer_freq_field;
  logic buzzer_enable;

  assign timer_enable = timer_two_control_one[timer_two_pkg::ctl1_timer_enable];
  assign reload_enable = timer_two_control_one[timer_two_pkg::ctl1_reload_enable];
  assign one_shot_select = timer_two_control_one[timer_two_pkg::ctl1_one_shot];
  assign shared_high_osc_select = timer_two_control_one[timer_two_pkg::ctl1_high_osc];
  assign pwm_active_low = timer_two_control_one[timer_two_pkg::ctl1_pwm_active_low];
  assign pwm_output_enable = timer_two_control_one[timer_two_pkg::ctl1_pwm_output_enable];
  assign prescale_rate_field = timer_two_control_two[timer_two_pkg::ctl2_rate_lsb +: 3];
  assign prescale_enable_n = timer_two_control_two[timer_two_pkg::ctl2_prescale_enable_n];
  assign ext_edge_select = timer_two_control_two[timer_two_pkg::ctl2_edge_select];
  assign clock_source_select = timer_two_control_two[timer_two_pkg::ctl2_clock_source];
  assign buzzer_freq_field = buzzer_two_control[timer_two_pkg::bz_freq_lsb +: 4];
  assign buzzer_enable = buzzer_two_control[timer_two_pkg::bz_enable];

  // ten-bit reload and duty values assembled from the shared high bits
  logic [9:0] reload_value;
  logic [9:0] duty_value;
  assign reload_value = {shared_timer_high_bits[timer_two_pkg::hb_reload_lsb +: 2], reload_low}; // R2
  assign duty_value = {shared_timer_high_bits[timer_two_pkg::hb_duty_lsb +: 2], pwm_two_duty_low}; // R15

  // ---------------- apb decode ----------------
  // byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = {22'h00_0000, idx, 2'b00};
  endfunction : reg_addr

  logic access; // access phase, waiting for our ready
  logic done; // the completing edge of a transfer
  logic wr_done;
  logic hit_count;
  logic hit_ctl1;
  logic hit_ctl2;
  logic hit_duty;
  logic hit_presc;
  logic hit_buzz;
  logic hit_high;
  logic mapped;
  logic byte0_wr; // write that carries the low byte lane

  assign access = psel & penable;
  assign done = access & pready;
  assign byte0_wr = done & pwrite & pstrb[0];
  assign wr_done = byte0_wr;
  assign hit_count = paddr == reg_addr(timer_two_pkg::idx_count);
  assign hit_ctl1 = paddr == reg_addr(timer_two_pkg::idx_control_one);
  assign hit_ctl2 = paddr == reg_addr(timer_two_pkg::idx_control_two);
  assign hit_duty = paddr == reg_addr(timer_two_pkg::idx_duty_low);
  assign hit_presc = paddr == reg_addr(timer_two_pkg::idx_prescale_count);
  assign hit_buzz = paddr == reg_addr(timer_two_pkg::idx_buzzer_control);
  assign hit_high = paddr == reg_addr(timer_two_pkg::idx_high_bits);
  assign mapped = hit_count | hit_ctl1 | hit_ctl2 | hit_duty | hit_presc | hit_buzz | hit_high;

  // read mux; write-only registers answer zero, upper bits always zero
  logic [7:0] prescale_value;
  logic [7:0] read_byte;
  assign read_byte = hit_count ? counter[7:0] : // R1
                     hit_ctl1 ? timer_two_control_one :
                     hit_ctl2 ? timer_two_control_two :
                     hit_presc ? prescale_value : // R16
                     hit_high ? shared_timer_high_bits : 8'h00;

  // one wait state: ready rises in the cycle after the access phase starts,
  // which lets read data come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= timer_two_pkg::read_zero;
    end else if (access & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? timer_two_pkg::read_zero : {24'h00_0000, read_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // configuration registers; writes land on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_two_control_one <= timer_two_pkg::rst_control_one;
      timer_two_control_two <= timer_two_pkg::rst_control_two;
      pwm_two_duty_low <= timer_two_pkg::rst_zero_byte;
      buzzer_two_control <= timer_two_pkg::rst_buzzer;
      shared_timer_high_bits <= timer_two_pkg::rst_zero_byte;
      reload_low <= timer_two_pkg::rst_zero_byte;
    end else if (wr_done) begin
      if (hit_ctl1) begin
        timer_two_control_one <= pwdata[7:0];
      end
      // rate is taken as written; keeping the divider off meanwhile is up to software
      if (hit_ctl2) begin
        timer_two_control_two <= pwdata[7:0]; // R11 R12
      end
      if (hit_duty) begin
        pwm_two_duty_low <= pwdata[7:0];
      end
      if (hit_buzz) begin
        buzzer_two_control <= pwdata[7:0];
      end
      if (hit_high) begin
        shared_timer_high_bits <= pwdata[7:0];
      end
      if (hit_count) begin
        reload_low <= pwdata[7:0]; // R2
      end
    end
  end

  // ---------------- clock source selection ----------------
  logic ext_rise;
  logic ext_fall;
  logic ext_tick;
  logic src_tick;

  ext_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_clock_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // edge select 1 counts falling edges, 0 rising edges
  assign ext_tick = ext_edge_select ? ext_fall : ext_rise; // R13
  // high oscillator overrides the per-channel source bit
  assign src_tick = shared_high_osc_select ? high_osc_tick : // R3
                    clock_source_select ? ext_tick : instr_tick; // R14

  prescale_if pif ();
  assign pif.src_tick = src_tick;
  assign pif.enable_n = prescale_enable_n;
  assign pif.rate = prescale_rate_field;
  assign prescale_value = pif.value;

  prescale_divider u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .pif(pif)
  );

  // ---------------- down-counter ----------------
  logic count_tick; // counter steps on this enable
  logic at_zero;
  logic underflow;
  logic count_write; // software load of the counter
  logic [9:0] next_counter;

  assign count_write = wr_done & hit_count;
  assign count_tick = pif.out_tick & timer_enable & ~stopped; // R4
  assign at_zero = counter == timer_two_pkg::counter_zero;
  assign underflow = count_tick & at_zero;
  // next counter value: software load, decrement, or restart value after underflow in free-running mode
  assign next_counter = count_write ? {shared_timer_high_bits[timer_two_pkg::hb_reload_lsb +: 2], pwdata[7:0]} : // R2
                        ~underflow ? counter - 10'h001 :
                        reload_enable ? reload_value : // R6
                        timer_two_pkg::counter_all_ones; // R5

  // software load wins over a tick in the same cycle so the written value is never skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= timer_two_pkg::counter_zero;
      stopped <= 1'b0;
    end else if (count_write) begin
      counter <= next_counter;
      stopped <= 1'b0;
    end else if (underflow & one_shot_select) begin
      stopped <= 1'b1; // R7
    end else if (count_tick) begin
      counter <= next_counter;
    end
  end

  // one-cycle underflow event for interrupt logic outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_underflow <= 1'b0;
    end else begin
      timer_underflow <= underflow; // R20
    end
  end

  // ---------------- pwm ----------------
  // frame length follows the reload since the counter restarts from it; compare is on ten bits
  logic pwm_active;
  assign pwm_active = counter <= duty_value; // R19 R15
  assign pwm_level = pwm_active ^ pwm_active_low; // R8

  // pins are registered; with the enable low the port keeps its general-purpose role
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pin_a_out <= 1'b0;
      pwm_pin_b_out <= 1'b0;
      pwm_pin_a_sel <= 1'b0;
      pwm_pin_b_sel <= 1'b0;
    end else begin
      pwm_pin_a_out <= pwm_output_enable & pwm_level; // R9
      pwm_pin_b_out <= pwm_output_enable & pwm_level; // R9
      pwm_pin_a_sel <= pwm_output_enable; // R9
      pwm_pin_b_sel <= pwm_output_enable; // R9
    end
  end

  // ---------------- buzzer ----------------
  // prescaler bit k toggles at source/2^(k+1); counter bit k follows the timer
  assign buzz_level = buzzer_freq_field[3] ? counter[buzzer_freq_field[2:0]] : // R17
                      prescale_value[buzzer_freq_field[2:0]]; // R17

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzzer_out <= 1'b0;
    end else begin
      buzzer_out <= buzzer_enable & buzz_level; // R18
    end
  end
endmodule : timer_two_unit

// file: timer_two_unit_checker.sv
// assertion checker bound to the timer two unit ports
`timescale 1ns/1ps
module timer_two_unit_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic instr_tick,
  input wire logic high_osc_tick,
  input wire logic ext_clock_pin,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_pin_a_out,
  input wire logic pwm_pin_a_sel,
  input wire logic pwm_pin_b_out,
  input wire logic pwm_pin_b_sel,
  input wire logic timer_underflow
);
  logic ext_prev; // pin level one cycle ago
  logic [3:0] ext_age; // cycles since the pin moved, saturating
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the age lets the underflow check allow for the synchroniser delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      ext_age <= 4'hf;
    end else begin
      ext_prev <= ext_clock_pin;
      ext_age <= (ext_clock_pin != ext_prev) ? 4'h0 : ((ext_age == 4'hf) ? ext_age : ext_age + 4'h1);
    end
  end
  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without request");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_pins_paired: assert property (pwm_pin_a_sel == pwm_pin_b_sel && pwm_pin_a_out == pwm_pin_b_out)
    else $error("pwm pins differ");
  a_gpio_quiet: assert property (!pwm_pin_a_sel |-> !pwm_pin_a_out)
    else $error("pwm level while pin is gpio");
  a_sel_after_write: assert property ($changed(pwm_pin_a_sel) |-> $past(pready && pwrite, 2))
    else $error("pin select moved without a write");
  a_underflow_cause: assert property (timer_underflow |-> $past(instr_tick) || $past(high_osc_tick) || ext_age <= 4'h6)
    else $error("underflow without a count tick");
endmodule : timer_two_unit_checker
bind timer_two_unit timer_two_unit_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .instr_tick,
  .high_osc_tick, .ext_clock_pin, .prdata, .pready, .pslverr, .pwm_pin_a_out, .pwm_pin_a_sel, .pwm_pin_b_out,
  .pwm_pin_b_sel, .timer_underflow);

// file: testbench.sv
// self-checking testbench for the timer two unit
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, instr_tick, high_osc_tick, ext_clock_pin;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0] pstrb; // tied on: every write carries its byte
  logic pready, pslverr, pwm_pin_a_out, pwm_pin_a_sel, pwm_pin_b_out, pwm_pin_b_sel, buzzer_out, timer_underflow;
  logic rerr;
  logic [9:0] v, ev;
  logic [7:0] m;
  int errors = 0;
  int cmp_count = 0;
  int uf_count = 0; // underflow pulses seen
  int n, r;
  timer_two_unit i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .instr_tick, .high_osc_tick, .ext_clock_pin, .pwm_pin_a_out, .pwm_pin_a_sel, .pwm_pin_b_out,
    .pwm_pin_b_sel, .buzzer_out, .timer_underflow);
  always #10 pclk = ~pclk;
  // count event pulses so each mode pass, free-run or one-shot, can be checked
  always @(posedge pclk) if (timer_underflow === 1'b1) uf_count++;
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h00_0000, d});
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e, input logic ee);
    apb(1'b0, idx, 32'h0000_0000);
    check(rdat, {24'h00_0000, e});
    check({31'h0, rerr}, {31'h0, ee});
  endtask : rd_chk
  // one-cycle enable pulses on the instruction or high oscillator input
  task automatic tick(input int cnt, input logic hosc);
    repeat (cnt) begin
      @(posedge pclk);
      instr_tick <= !hosc;
      high_osc_tick <= hosc;
      @(posedge pclk);
      instr_tick <= 1'b0;
      high_osc_tick <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask : tick
  task automatic pin(input logic lvl);
    @(posedge pclk);
    ext_clock_pin <= lvl;
    repeat (8) @(posedge pclk);
  endtask : pin
  task automatic pins_chk(input logic [3:0] e);
    repeat (3) @(posedge pclk);
    check({28'h0, pwm_pin_b_sel, pwm_pin_b_out, pwm_pin_a_sel, pwm_pin_a_out}, {28'h0, e});
  endtask : pins_chk
  // down-counter after n ticks; one-shot simply stays at zero
  function automatic logic [9:0] model(input logic [9:0] c, input logic [9:0] rl, input logic [7:0] md, input int t);
    for (int i = 0; i < t; i++) begin
      if (c != 10'h000) c = c - 10'h001;
      else if (!md[2]) c = md[1] ? rl : 10'h3ff;
    end
    return c;
  endfunction : model
  initial begin
    #1_000_000;
    errors++;
    test_done();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, instr_tick, high_osc_tick, ext_clock_pin} = 8'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    void'($urandom(7311));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(timer_two_pkg::idx_count, 8'h00, 1'b0);
    rd_chk(timer_two_pkg::idx_control_one, 8'h00, 1'b0);
    rd_chk(timer_two_pkg::idx_control_two, 8'h3f, 1'b0);
    rd_chk(timer_two_pkg::idx_duty_low, 8'h00, 1'b0);
    rd_chk(timer_two_pkg::idx_prescale_count, 8'hff, 1'b0);
    rd_chk(timer_two_pkg::idx_buzzer_control, 8'h00, 1'b0);
    rd_chk(8'h3f, 8'h00, 1'b1);
    $display("test reset done");
    v = 10'($urandom);
    wr(timer_two_pkg::idx_high_bits, {v[9:8], 6'h00});
    wr(timer_two_pkg::idx_count, v[7:0]);
    wr(timer_two_pkg::idx_control_two, 8'h08);
    tick(3, 1'b0);
    rd_chk(timer_two_pkg::idx_count, v[7:0], 1'b0);
    wr(timer_two_pkg::idx_high_bits, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = 8'h01 | 8'(i << 1);
      v = 10'(3 + $urandom % 6);
      n = int'(v) + 1 + int'($urandom % 4);
      wr(timer_two_pkg::idx_control_one, m);
      wr(timer_two_pkg::idx_count, v[7:0]);
      r = uf_count;
      tick(n, 1'b0);
      ev = model(v, v, m, n);
      rd_chk(timer_two_pkg::idx_count, ev[7:0], 1'b0);
      check(32'(uf_count - r), 32'h0000_0001);
    end
    $display("test modes done");
    wr(timer_two_pkg::idx_control_two, 8'h28);
    wr(timer_two_pkg::idx_control_one, 8'h09);
    wr(timer_two_pkg::idx_count, 8'h20);
    tick(3, 1'b1);
    tick(2, 1'b0);
    rd_chk(timer_two_pkg::idx_count, 8'h1d, 1'b0);
    wr(timer_two_pkg::idx_control_one, 8'h01);
    tick(2, 1'b1);
    tick(2, 1'b0);
    rd_chk(timer_two_pkg::idx_count, 8'h1d, 1'b0);
    pin(1'b1);
    pin(1'b0);
    rd_chk(timer_two_pkg::idx_count, 8'h1c, 1'b0);
    wr(timer_two_pkg::idx_control_two, 8'h38);
    pin(1'b1);
    pin(1'b0);
    rd_chk(timer_two_pkg::idx_count, 8'h1b, 1'b0);
    $display("test sources done");
    for (int j = 0; j < 3; j++) begin
      r = (j == 0) ? 0 : ((j == 1) ? 7 : int'($urandom % 8));
      n = (2 << r) * 2 - 1;
      wr(timer_two_pkg::idx_control_two, 8'h08 | 8'(r));
      wr(timer_two_pkg::idx_control_two, 8'(r));
      wr(timer_two_pkg::idx_count, 8'h40);
      tick(n, 1'b0);
      rd_chk(timer_two_pkg::idx_count, 8'h3f, 1'b0);
      rd_chk(timer_two_pkg::idx_prescale_count, 8'hff - 8'(n), 1'b0);
      tick(1, 1'b0);
      rd_chk(timer_two_pkg::idx_count, 8'h3e, 1'b0);
      // park the divider before the next rate change
      wr(timer_two_pkg::idx_control_two, 8'h08 | 8'(r));
    end
    $display("test prescaler done");
    wr(timer_two_pkg::idx_control_one, 8'h00);
    wr(timer_two_pkg::idx_control_two, 8'h08);
    wr(timer_two_pkg::idx_high_bits, 8'h00);
    wr(timer_two_pkg::idx_duty_low, 8'h05);
    wr(timer_two_pkg::idx_count, 8'h0a);
    wr(timer_two_pkg::idx_control_one, 8'h80);
    pins_chk(4'b1010);
    wr(timer_two_pkg::idx_control_one, 8'hc0);
    pins_chk(4'b1111);
    wr(timer_two_pkg::idx_count, 8'h03);
    pins_chk(4'b1010);
    wr(timer_two_pkg::idx_control_one, 8'h80);
    pins_chk(4'b1111);
    wr(timer_two_pkg::idx_high_bits, 8'h04);
    wr(timer_two_pkg::idx_count, 8'h0a);
    pins_chk(4'b1111);
    wr(timer_two_pkg::idx_high_bits, 8'h40);
    wr(timer_two_pkg::idx_duty_low, 8'hff);
    wr(timer_two_pkg::idx_count, 8'h00);
    pins_chk(4'b1010);
    wr(timer_two_pkg::idx_control_one, 8'h00);
    pins_chk(4'b0000);
    $display("test pwm done");
    v = 10'($urandom);
    wr(timer_two_pkg::idx_count, v[7:0]);
    // run the divider a random distance so every prescaler bit is exercised
    wr(timer_two_pkg::idx_control_two, 8'h00);
    n = int'($urandom % 200);
    tick(n, 1'b0);
    m = 8'hff - 8'(n);
    for (int c = 0; c < 16; c++) begin
      wr(timer_two_pkg::idx_buzzer_control, 8'h80 | 8'(c));
      repeat (3) @(posedge pclk);
      check({31'h0, buzzer_out}, {31'h0, (c < 8) ? m[c] : v[c - 8]});
    end
    wr(timer_two_pkg::idx_buzzer_control, 8'h00);
    repeat (3) @(posedge pclk);
    check({31'h0, buzzer_out}, 32'h0000_0000);
    $display("test buzzer done");
    test_done();
  end
endmodule : testbench
